// ---- acr_pkg.sv ----
/*
 * acr_pkg: constants, enums and carrier structs for the ADC
 * configuration word, the zero/span trim words and self calibration.
 * Assumes a 10 MHz core clock and a 24-bit register access path.
 */
`default_nettype none

package acr_pkg;

  // ----------------------------------------------------------------
  // configuration word layout
  // ----------------------------------------------------------------
  localparam int CFG_W = 24;
  localparam int POS_MC = 18;
  localparam int POS_LP = 17;
  localparam int POS_RC = 16;
  localparam int POS_PSS = 11;
  localparam int POS_PUMP_OFF = 10;
  localparam int POS_PSR = 9;
  localparam int POS_LPM = 8;
  localparam int POS_SRST = 7;
  localparam int POS_RDONE = 6;
  localparam int POS_OSC = 5;
  localparam int POS_OVR = 4;
  // host-writable bits outside the soft reset bit
  localparam logic [23:0] CFG_WMASK = 24'h37_FF00;

  // ----------------------------------------------------------------
  // reset values and arithmetic limits
  // ----------------------------------------------------------------
  localparam logic [23:0] CFG_RESET = 24'h00_0040;
  localparam logic [23:0] ZERO_RESET = 24'h00_0000;
  localparam logic [23:0] SPAN_RESET = 24'h40_0000;
  localparam logic [23:0] FULL_CODE = 24'hFF_FFFF;
  localparam logic [23:0] SPAN_MAX = 24'hFF_FFFF;
  localparam int SPAN_FRAC = 22;
  localparam int DIV_STEPS = 24;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_NS = 100;
  localparam int SRST_TIME_NS = 800;
  localparam int SRST_CYC = (SRST_TIME_NS + CLK_NS - 1) / CLK_NS;

  // ----------------------------------------------------------------
  // enums and carriers
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {SEL_SETUP, SEL_ZERO, SEL_SPAN, SEL_NONE} acr_sel_e;
  typedef enum logic [1:0] {CAL_SELF_OFS, CAL_SELF_GAIN, CAL_SYS_OFS, CAL_SYS_GAIN} acr_cal_e;
  typedef enum logic [1:0] {
    ROUTE_INPUT, ROUTE_AMP_TO_AIN_NEG, ROUTE_MOD_TO_VREF_NEG, ROUTE_MOD_ACROSS_VREF
  } acr_route_e;

  typedef struct packed {
    logic [23:0] zero;
    logic [23:0] span;
  } acr_trim_s;

  typedef struct packed {
    logic valid;
    logic [23:0] raw;
    logic above_pos_fs;
    logic below_zero;
    logic below_neg_fs;
  } acr_conv_s;

  typedef struct packed {
    logic run;
    logic standby;
    logic sleep;
    logic reduced;
  } acr_power_s;

endpackage : acr_pkg

`default_nettype wire

// ---- acr_core.sv ----
/*
 * acr_core: configuration word, zero/span trim words, soft reset,
 * error flags, self/system calibration and trim-corrected data.
 * Assumes a serial front end that issues one-cycle register strobes,
 * and a modulator/filter that presents one raw result per conversion.
 */
// Summary of operation
// - pump-off bit set floats the charge pump drive pin, clear drives it
// - reduced-power bit selects low power, only on high-resolution variants
// - writing soft reset 1 starts reset; host writes 0 to leave it
// - reset-done flag sets after reset cycle, cleared by reading setup word
// - oscillation flag follows modulator oscillation detection
// - overrange flag sets above full scale or below zero/negative scale
// - without calibration, unity span and zero offset still convert
// - one zero trim LSB weighs 2^-24 of span at unity gain
// - zero trim top bit is the sign, 1 meaning negative correction
// - span trim is unsigned, top bit weighs 2, then 1, halving onward
// - reset loads span trim with only the bit below the top set
// - zero trim aligns with data word at the most significant bits
// - each offset or gain calibration completes within one conversion
// - serial data output falls when a calibration step finishes
// - low-range self offset shorts amp inputs onto negative analog input
// - high-range self offset shorts modulator inputs onto negative reference
// - self gain puts modulator inputs across the reference pair
// - four calibrations: self and system, offset and gain, by command
// - while soft reset is set, writes to other setup bits are ignored
// - reset gives setup 000040h, zero trim zero and span trim 400000h
`timescale 1ns/1ps
`default_nettype none

module acr_core
  import acr_pkg::*;
#(
  parameter int DATA_W = 24,
  parameter bit HIGH_RES = 1'b1,
  parameter int PUMP_DIV = 4
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire acr_sel_e reg_sel,
  input wire logic [23:0] reg_wdata,
  output logic [23:0] reg_rdata,
  input wire acr_conv_s conv,
  input wire logic bipolar_mode,
  input wire logic osc_detect,
  input wire logic cal_start,
  input wire acr_cal_e cal_kind,
  input wire logic cal_low_range,
  output logic charge_pump_drive_pin_o,
  output logic charge_pump_drive_pin_oe_n,
  output acr_power_s power,
  output logic seq_mc,
  output logic seq_lp,
  output logic seq_rc,
  output logic cal_busy,
  output acr_route_e cal_route,
  output logic sdo_cal_o,
  output logic soft_reset_active,
  output acr_trim_s trim,
  output logic corr_valid,
  output logic [DATA_W-1:0] corr_data
);

  // ----------------------------------------------------------------
  // elaboration checks
  // ----------------------------------------------------------------
  if (DATA_W != 16 && DATA_W != 24) begin : g_bad_width
    $error("acr_core: DATA_W must be 16 or 24");
  end
  if (PUMP_DIV < 1 || PUMP_DIV > 255) begin : g_bad_div
    $error("acr_core: PUMP_DIV must be 1..255");
  end

  // ----------------------------------------------------------------
  // configuration word and soft reset
  // ----------------------------------------------------------------
  logic [23:0] cfg;
  logic [23:0] next_cfg;
  logic [3:0] srst_cnt;
  logic [3:0] next_srst_cnt;
  logic srst_done;
  logic cal_active;
  logic setup_wr;
  logic setup_rd;

  assign setup_wr = reg_wr && reg_sel == SEL_SETUP;
  assign setup_rd = reg_rd && reg_sel == SEL_SETUP;
  assign srst_done = srst_cnt == 4'(1);

  // next setup word: writes, reset cycle, flags
  always_comb begin
    next_cfg = cfg;
    next_srst_cnt = srst_cnt;
    if (setup_wr) begin
      if (cfg[POS_SRST]) begin
        next_cfg[POS_SRST] = reg_wdata[POS_SRST];
      end else begin
        next_cfg = (cfg & ~CFG_WMASK) | (reg_wdata & CFG_WMASK);
        next_cfg[POS_SRST] = reg_wdata[POS_SRST];
        if (reg_wdata[POS_SRST]) begin
          next_srst_cnt = 4'(SRST_CYC);
        end
      end
    end
    if (srst_cnt != 4'(0)) begin
      next_srst_cnt = srst_cnt - 4'(1);
    end
    // read clears reset-done before a finishing cycle can set it
    if (setup_rd) begin
      next_cfg[POS_RDONE] = 1'b0;
    end
    if (srst_done) begin
      next_cfg = CFG_RESET;
      next_cfg[POS_SRST] = 1'b1;
      next_cfg[POS_RDONE] = 1'b1;
    end
    next_cfg[POS_OSC] = osc_detect;
    if (conv.valid && !cal_active) begin
      next_cfg[POS_OVR] = conv.above_pos_fs
        || (bipolar_mode ? conv.below_neg_fs : conv.below_zero);
    end
    next_cfg[3:0] = 4'h0;
  end

  // setup word registers
  always_ff @(posedge core_clk) begin
    if (rst) begin
      cfg <= CFG_RESET;
      srst_cnt <= 4'h0;
    end else if (ce) begin
      cfg <= next_cfg;
      srst_cnt <= next_srst_cnt;
    end
  end

  // ----------------------------------------------------------------
  // calibration sequencer and trim words
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_DIV} acr_cal_st_e;
  acr_cal_st_e st;
  acr_cal_st_e next_st;
  acr_cal_e kind;
  acr_cal_e next_kind;
  logic low_rng;
  logic next_low_rng;
  logic [23:0] zero;
  logic [23:0] next_zero;
  logic [23:0] span;
  logic [23:0] next_span;
  logic [26:0] rem;
  logic [26:0] next_rem;
  logic [23:0] quo;
  logic [23:0] next_quo;
  logic [25:0] dvs;
  logic [25:0] next_dvs;
  logic [4:0] step;
  logic [4:0] next_step;
  logic sdo;
  logic next_sdo;
  logic gain_kind;
  logic [26:0] trial;

  assign cal_active = st != ST_IDLE;
  assign gain_kind = kind == CAL_SELF_GAIN || kind == CAL_SYS_GAIN;
  assign trial = rem - {1'b0, dvs};

  // next calibration state, divider step and trim values
  always_comb begin
    next_st = st;
    next_kind = kind;
    next_low_rng = low_rng;
    next_zero = zero;
    next_span = span;
    next_rem = rem;
    next_quo = quo;
    next_dvs = dvs;
    next_step = step;
    next_sdo = sdo;
    if (reg_wr && !cfg[POS_SRST] && reg_sel == SEL_ZERO) begin
      next_zero = reg_wdata;
    end
    if (reg_wr && !cfg[POS_SRST] && reg_sel == SEL_SPAN) begin
      next_span = reg_wdata;
    end
    case (st)
      ST_IDLE: begin
        if (cal_start && !cfg[POS_SRST]) begin
          next_kind = cal_kind;
          next_low_rng = cal_low_range;
          next_sdo = 1'b1;
          next_st = ST_WAIT;
        end
      end
      ST_WAIT: begin
        // one conversion result closes an offset step; a gain step may go on to divide
        if (conv.valid) begin
          if (!gain_kind) begin
            next_zero = 24'(~conv.raw + 24'h00_0001);
            next_sdo = 1'b0;
            next_st = ST_IDLE;
          end else if ({2'b00, conv.raw, 2'b00} <= {4'h0, FULL_CODE}) begin
            next_span = SPAN_MAX;
            next_sdo = 1'b0;
            next_st = ST_IDLE;
          end else begin
            next_rem = {3'b000, FULL_CODE};
            next_dvs = {1'b0, conv.raw, 1'b0};
            next_quo = 24'h00_0000;
            next_step = 5'(DIV_STEPS);
            next_st = ST_DIV;
          end
        end
      end
      ST_DIV: begin
        // restoring divide: span = full code * 2^22 / raw result
        if (!trial[26]) begin
          next_rem = {trial[25:0], 1'b0};
          next_quo = {quo[22:0], 1'b1};
        end else begin
          next_rem = {rem[25:0], 1'b0};
          next_quo = {quo[22:0], 1'b0};
        end
        next_step = step - 5'(1);
        if (step == 5'(1)) begin
          next_span = next_quo;
          next_sdo = 1'b0;
          next_st = ST_IDLE;
        end
      end
      default: begin
        next_st = ST_IDLE;
      end
    endcase
    if (srst_done) begin
      next_zero = ZERO_RESET;
      next_span = SPAN_RESET;
      next_sdo = 1'b0;
      next_st = ST_IDLE;
    end
  end

  // calibration and trim registers
  always_ff @(posedge core_clk) begin
    if (rst) begin
      st <= ST_IDLE;
      kind <= CAL_SELF_OFS;
      low_rng <= 1'b0;
      zero <= ZERO_RESET;
      span <= SPAN_RESET;
      rem <= 27'h000_0000;
      quo <= 24'h00_0000;
      dvs <= 26'h000_0000;
      step <= 5'h00;
      sdo <= 1'b0;
    end else if (ce) begin
      st <= next_st;
      kind <= next_kind;
      low_rng <= next_low_rng;
      zero <= next_zero;
      span <= next_span;
      rem <= next_rem;
      quo <= next_quo;
      dvs <= next_dvs;
      step <= next_step;
      sdo <= next_sdo;
    end
  end

  // input routing during self calibration
  always_comb begin
    cal_route = ROUTE_INPUT;
    if (cal_active && kind == CAL_SELF_OFS) begin
      cal_route = low_rng ? ROUTE_AMP_TO_AIN_NEG
                          : ROUTE_MOD_TO_VREF_NEG;
    end else if (cal_active && kind == CAL_SELF_GAIN) begin
      cal_route = ROUTE_MOD_ACROSS_VREF;
    end
  end

  // ----------------------------------------------------------------
  // register read port
  // ----------------------------------------------------------------
  logic [23:0] next_rdata;

  // select read word; reserved selection reads zero
  always_comb begin
    next_rdata = reg_rdata;
    if (reg_rd) begin
      if (reg_sel == SEL_SETUP) begin
        next_rdata = cfg;
      end else if (reg_sel == SEL_ZERO) begin
        next_rdata = zero;
      end else if (reg_sel == SEL_SPAN) begin
        next_rdata = span;
      end else begin
        next_rdata = 24'h00_0000;
      end
    end
  end

  // read data register
  always_ff @(posedge core_clk) begin
    if (rst) begin
      reg_rdata <= 24'h00_0000;
    end else if (ce) begin
      reg_rdata <= next_rdata;
    end
  end

  // ----------------------------------------------------------------
  // trim-corrected conversion data
  // ----------------------------------------------------------------
  logic signed [24:0] raw_s;
  logic signed [24:0] sum_s;
  logic signed [49:0] prod_s;
  logic signed [49:0] scaled_s;
  logic [23:0] sat;
  logic [23:0] corr24;
  logic [23:0] next_corr24;
  logic next_corr_valid;

  // (raw + zero) * span / 2^22, zero sign-extended and MSB aligned
  always_comb begin
    raw_s = bipolar_mode ? {conv.raw[23], conv.raw} : {1'b0, conv.raw};
    sum_s = raw_s + {zero[23], zero};
    prod_s = 50'(sum_s) * $signed({26'h000_0000, span});
    scaled_s = prod_s >>> SPAN_FRAC;
    if (bipolar_mode) begin
      if (scaled_s > 50'sh7F_FFFF) begin
        sat = 24'h7F_FFFF;
      end else if (scaled_s < -50'sh80_0000) begin
        sat = 24'h80_0000;
      end else begin
        sat = scaled_s[23:0];
      end
    end else begin
      if (scaled_s > 50'shFF_FFFF) begin
        sat = 24'hFF_FFFF;
      end else if (scaled_s < 50'sh0) begin
        sat = 24'h00_0000;
      end else begin
        sat = scaled_s[23:0];
      end
    end
    next_corr_valid = conv.valid && !cal_active;
    next_corr24 = next_corr_valid ? sat : corr24;
  end

  // corrected data registers
  always_ff @(posedge core_clk) begin
    if (rst) begin
      corr24 <= 24'h00_0000;
      corr_valid <= 1'b0;
    end else if (ce) begin
      corr24 <= next_corr24;
      corr_valid <= next_corr_valid;
    end
  end

  assign corr_data = corr24[23 -: DATA_W];

  // ----------------------------------------------------------------
  // charge pump drive
  // ----------------------------------------------------------------
  logic [7:0] pump_cnt;
  logic [7:0] next_pump_cnt;
  logic pump_q;
  logic next_pump_q;

  // square wave divider, cleared to zero and stopped while the pump is off
  always_comb begin
    next_pump_cnt = pump_cnt;
    next_pump_q = pump_q;
    if (cfg[POS_PUMP_OFF]) begin
      next_pump_cnt = 8'h00;
      next_pump_q = 1'b0;
    end else if (pump_cnt == 8'(PUMP_DIV - 1)) begin
      next_pump_cnt = 8'h00;
      next_pump_q = !pump_q;
    end else begin
      next_pump_cnt = pump_cnt + 8'h01;
    end
  end

  // pump divider registers
  always_ff @(posedge core_clk) begin
    if (rst) begin
      pump_cnt <= 8'h00;
      pump_q <= 1'b0;
    end else if (ce) begin
      pump_cnt <= next_pump_cnt;
      pump_q <= next_pump_q;
    end
  end

  assign charge_pump_drive_pin_o = pump_q;
  assign charge_pump_drive_pin_oe_n = cfg[POS_PUMP_OFF];

  // ----------------------------------------------------------------
  // power, sequencing and status outputs
  // ----------------------------------------------------------------
  // power state from run bit and save select
  always_comb begin
    power.run = !cfg[POS_PSR];
    power.standby = cfg[POS_PSR] && !cfg[POS_PSS];
    power.sleep = cfg[POS_PSR] && cfg[POS_PSS];
    power.reduced = HIGH_RES && cfg[POS_LPM];
  end

  // mode bits masked while a calibration step runs
  assign seq_mc = cfg[POS_MC] && !cal_active;
  assign seq_lp = cfg[POS_LP] && !cal_active;
  assign seq_rc = cfg[POS_RC] && !cal_active;
  assign cal_busy = cal_active;
  assign sdo_cal_o = sdo;
  assign soft_reset_active = cfg[POS_SRST];
  assign trim.zero = zero;
  assign trim.span = span;

endmodule : acr_core

`default_nettype wire

// ---- acr_core_asserts.sv ----
/* acr_core_asserts: port-level checks on acr_core.
   Assumes one core clock and a synchronous active-high reset. */
`timescale 1ns/1ps
`default_nettype none

module acr_core_asserts
  import acr_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic reg_wr,
  input wire acr_sel_e reg_sel,
  input wire logic [23:0] reg_wdata,
  input wire acr_conv_s conv,
  input wire logic cal_start,
  input wire acr_cal_e cal_kind,
  input wire logic cal_low_range,
  input wire logic charge_pump_drive_pin_oe_n,
  input wire acr_power_s power,
  input wire logic seq_mc,
  input wire logic seq_lp,
  input wire logic seq_rc,
  input wire logic cal_busy,
  input wire acr_route_e cal_route,
  input wire logic sdo_cal_o,
  input wire logic soft_reset_active,
  input wire acr_trim_s trim,
  input wire logic corr_valid
);
  // ------------------
  // accepted requests
  // ------------------
  logic set_wr;
  logic cal_go;
  // setup write and calibration start that the block takes
  assign set_wr = ce && reg_wr && (reg_sel == SEL_SETUP) && !soft_reset_active;
  assign cal_go = ce && cal_start && !cal_busy && !soft_reset_active;

  default clocking acr_cb @(posedge core_clk);
  endclocking
  default disable iff (rst);

  // ------------------
  // assertions
  // ------------------
  a_pump_follows_bit: assert property (set_wr |=>
    charge_pump_drive_pin_oe_n == $past(reg_wdata[POS_PUMP_OFF]))
    else $error("pump enable differs from setup bit");
  a_power_run_bit: assert property (set_wr |=>
    power.run == !$past(reg_wdata[POS_PSR]))
    else $error("run state differs from setup bit");
  a_srst_enter: assert property (set_wr && reg_wdata[POS_SRST] |=> soft_reset_active)
    else $error("soft reset not entered");
  a_srst_blocks_cal: assert property (soft_reset_active && cal_start && !cal_busy |=> !cal_busy)
    else $error("calibration started in soft reset");
  a_cal_start_seen: assert property (cal_go |=> cal_busy && sdo_cal_o)
    else $error("calibration start not taken");
  a_cal_bounded: assert property (cal_busy && conv.valid |-> ##[1:25] !cal_busy)
    else $error("calibration step too long");
  a_sdo_end_low: assert property ($fell(cal_busy) |-> !sdo_cal_o && cal_route == ROUTE_INPUT)
    else $error("serial output high after calibration");
  a_route_low: assert property ($rose(cal_busy) && $past(cal_low_range) &&
    $past(cal_kind) == CAL_SELF_OFS |-> cal_route == ROUTE_AMP_TO_AIN_NEG)
    else $error("low range offset route wrong");
  a_route_gain: assert property ($rose(cal_busy) && $past(cal_kind) == CAL_SELF_GAIN |->
    cal_route == ROUTE_MOD_ACROSS_VREF)
    else $error("self gain route wrong");
  a_seq_masked: assert property (cal_busy |-> !seq_mc && !seq_lp && !seq_rc)
    else $error("sequencer bits live in calibration");
  a_span_unity: assert property ($fell(rst) |-> trim == {ZERO_RESET, SPAN_RESET})
    else $error("trim words wrong after reset");
  a_data_pass: assert property (ce && conv.valid && !cal_busy |=> corr_valid)
    else $error("conversion gave no data");
endmodule : acr_core_asserts

bind acr_core acr_core_asserts acr_core_asserts_inst (
  .core_clk, .rst, .ce, .reg_wr, .reg_sel, .reg_wdata, .conv, .cal_start, .cal_kind,
  .cal_low_range, .charge_pump_drive_pin_oe_n, .power, .seq_mc, .seq_lp, .seq_rc,
  .cal_busy, .cal_route, .sdo_cal_o, .soft_reset_active, .trim, .corr_valid
);
`default_nettype wire

// ---- acr_host.sv ----
/* acr_host: host model on the register strobe port.
   Assumes strobes are taken on the rising core clock edge. */
`timescale 1ns/1ps
`default_nettype none

module acr_host
  import acr_pkg::*;
(
  input wire logic core_clk,
  output logic reg_wr,
  output logic reg_rd,
  output acr_sel_e reg_sel,
  output logic [23:0] reg_wdata,
  input wire logic [23:0] reg_rdata
);
  // ------------------
  // strobe tasks
  // ------------------
  logic [23:0] last_rd;

  // port idle at time zero
  initial begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_sel = SEL_NONE;
    reg_wdata = 24'h00_0000;
    last_rd = 24'h00_0000;
  end

  // one-cycle write; released data inverted so stale values never match
  task automatic wr(input acr_sel_e sel, input logic [23:0] data);
    logic [23:0] d;
    d = data;
    if (sel == SEL_SETUP) begin
      d[3:0] = 4'h0;
      d[POS_PUMP_OFF] = d[POS_PUMP_OFF] | (d[POS_PSR] & !d[POS_PSS]);
    end
    @(posedge core_clk);
    #1;
    reg_sel = sel;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(posedge core_clk);
    #1;
    reg_wr = 1'b0;
    reg_wdata = ~d;
  endtask : wr

  // one-cycle read, data taken after the answering edge
  task automatic rd(input acr_sel_e sel);
    @(posedge core_clk);
    #1;
    reg_sel = sel;
    reg_rd = 1'b1;
    @(posedge core_clk);
    #1;
    reg_rd = 1'b0;
    last_rd = reg_rdata;
  endtask : rd

  // leave soft reset, then a separate write for the other bits
  task automatic leave_reset(input logic [23:0] data);
    wr(SEL_SETUP, 24'h00_0000);
    wr(SEL_SETUP, data);
  endtask : leave_reset
endmodule : acr_host
`default_nettype wire

// ---- tb_top.sv ----
/* tb_top: self-checking bench for acr_core with a host model.
   Assumes acr_core, acr_host and the bound checker are compiled. */
`timescale 1ns/1ps
`default_nettype none

module tb_top
  import acr_pkg::*;
();
  // ------------------
  // signals and parts
  // ------------------
  logic core_clk;
  logic rst;
  logic ce;
  logic reg_wr;
  logic reg_rd;
  acr_sel_e reg_sel;
  logic [23:0] reg_wdata;
  logic [23:0] reg_rdata;
  acr_conv_s conv;
  logic bipolar_mode;
  logic osc_detect;
  logic cal_start;
  acr_cal_e cal_kind;
  logic cal_low_range;
  logic charge_pump_drive_pin_o;
  logic charge_pump_drive_pin_oe_n;
  acr_power_s power;
  logic seq_mc;
  logic seq_lp;
  logic seq_rc;
  logic cal_busy;
  acr_route_e cal_route;
  logic sdo_cal_o;
  logic soft_reset_active;
  acr_trim_s trim;
  logic corr_valid;
  logic [23:0] corr_data;
  int bad_count;
  int check_count;
  logic pump_seen;
  typedef struct packed {
    acr_sel_e sel;
    logic [23:0] wdata;
    logic [23:0] rexp;
    logic [4:0] pwr_pump;
  } acr_row_s;
  // register rows: write, read back, power state and pump enable
  localparam acr_row_s ROWS [9] = '{
    '{SEL_SETUP, 24'h00_0200, 24'h00_0600, 5'b0100_1},
    '{SEL_SETUP, 24'h00_0B00, 24'h00_0B00, 5'b0011_0},
    '{SEL_SETUP, 24'hFF_FF00, 24'h37_FF00, 5'b0011_1},
    '{SEL_SETUP, 24'h00_0000, 24'h00_0000, 5'b1000_0},
    '{SEL_ZERO, 24'h80_0001, 24'h80_0001, 5'b1000_0},
    '{SEL_SPAN, 24'hFF_FFFF, 24'hFF_FFFF, 5'b1000_0},
    '{SEL_NONE, 24'h12_3456, 24'h00_0000, 5'b1000_0},
    '{SEL_SPAN, 24'h40_0000, 24'h40_0000, 5'b1000_0},
    '{SEL_ZERO, 24'h00_0000, 24'h00_0000, 5'b1000_0}};
  // overrange rows: bipolar, three range flags, expected flag
  localparam logic [4:0] OVR [5] = '{5'b0_100_1, 5'b0_010_1, 5'b1_010_0, 5'b1_001_1,
    5'b0_000_0};

  // clock enable tied high: freezing is not under test
  acr_core acr_core_inst (
    .core_clk, .rst, .ce, .reg_wr, .reg_rd, .reg_sel, .reg_wdata, .reg_rdata, .conv,
    .bipolar_mode, .osc_detect, .cal_start, .cal_kind, .cal_low_range,
    .charge_pump_drive_pin_o, .charge_pump_drive_pin_oe_n, .power, .seq_mc, .seq_lp,
    .seq_rc, .cal_busy, .cal_route, .sdo_cal_o, .soft_reset_active, .trim, .corr_valid,
    .corr_data);
  acr_host acr_host_inst (.core_clk, .reg_wr, .reg_rd, .reg_sel, .reg_wdata, .reg_rdata);

  // ------------------
  // tasks
  // ------------------
  // compare and count
  task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // read a register and compare
  task automatic rdc(input acr_sel_e sel, input logic [23:0] exp, input string what);
    acr_host_inst.rd(sel);
    chk(what, exp, acr_host_inst.last_rd);
  endtask : rdc

  // one conversion result with its range flags
  task automatic cv(input logic [23:0] raw, input logic [2:0] fl);
    @(posedge core_clk);
    #1;
    conv = {1'b1, raw, fl};
    @(posedge core_clk);
    #1;
    conv = {1'b0, ~raw, 3'b000};
  endtask : cv

  // one calibration step from start to its end
  task automatic cal(input acr_cal_e kind, input logic low, input acr_route_e route,
                     input logic [23:0] raw);
    @(posedge core_clk);
    #1;
    cal_start = 1'b1;
    cal_kind = kind;
    cal_low_range = low;
    @(posedge core_clk);
    #1;
    cal_start = 1'b0;
    chk("cal start", 24'({2'b11, route}), {20'h0, cal_busy, sdo_cal_o, cal_route});
    cv(raw, 3'b000);
    chk("data in cal", 24'h00_0000, 24'(corr_valid));
    for (int i = 0; i < 30 && cal_busy !== 1'b0; i++) begin
      @(posedge core_clk);
      #1;
    end
    chk("cal end", 24'h00_0000, {20'h0, cal_busy, sdo_cal_o, cal_route});
  endtask : cal

  // verdict and end of run
  task automatic stop_test();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : stop_test

  // ------------------
  // processes
  // ------------------
  // core clock
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  // watchdog, well past the roughly 170 cycles the tests take
  initial begin
    #500_000;
    bad_count++;
    $display("BAD watchdog expected end seen timeout");
    stop_test();
  end

  // main sequence
  initial begin
    bad_count = 0;
    check_count = 0;
    rst = 1'b1;
    ce = 1'b1;
    conv = '0;
    bipolar_mode = 1'b0;
    osc_detect = 1'b0;
    cal_start = 1'b0;
    cal_kind = CAL_SELF_OFS;
    cal_low_range = 1'b0;
    repeat (3) @(posedge core_clk);
    #1;
    rst = 1'b0;
    rdc(SEL_SETUP, 24'h00_0040, "setup at reset");
    rdc(SEL_SETUP, 24'h00_0000, "done flag after read");
    rdc(SEL_SPAN, 24'h40_0000, "span at reset");
    rdc(SEL_ZERO, 24'h00_0000, "zero at reset");
    chk("pump at reset", 24'h00_0000, 24'(charge_pump_drive_pin_oe_n));
    // pump drive must toggle once per divider span while enabled
    pump_seen = charge_pump_drive_pin_o;
    repeat (acr_core_inst.PUMP_DIV) @(posedge core_clk);
    #1;
    chk("pump toggles", 24'(!pump_seen), 24'(charge_pump_drive_pin_o));
    cv(24'h12_3456, 3'b000);
    chk("unity data", 24'h12_3456, corr_data);
    acr_host_inst.wr(SEL_ZERO, 24'h00_0010);
    cv(24'h00_0100, 3'b000);
    chk("offset lsb", 24'h00_0110, corr_data);
    acr_host_inst.wr(SEL_ZERO, 24'hFF_FFF0);
    cv(24'h00_0100, 3'b000);
    chk("negative offset", 24'h00_00F0, corr_data);
    foreach (ROWS[i]) begin
      acr_host_inst.wr(ROWS[i].sel, ROWS[i].wdata);
      rdc(ROWS[i].sel, ROWS[i].rexp, "row readback");
      chk("power and pump", 24'(ROWS[i].pwr_pump),
          24'({power, charge_pump_drive_pin_oe_n}));
    end
    acr_host_inst.wr(SEL_SPAN, 24'h80_0000);
    cv(24'h00_0100, 3'b000);
    chk("span top bit", 24'h00_0200, corr_data);
    // soft reset with ignored writes and a refused calibration
    acr_host_inst.wr(SEL_ZERO, 24'h00_1234);
    acr_host_inst.wr(SEL_SETUP, 24'h00_0080);
    chk("soft reset on", 24'h00_0001, 24'(soft_reset_active));
    acr_host_inst.wr(SEL_SETUP, 24'h00_0480);
    acr_host_inst.wr(SEL_SPAN, 24'h00_1111);
    cal_start = 1'b1;
    @(posedge core_clk);
    #1;
    cal_start = 1'b0;
    chk("cal refused", 24'h00_0000, 24'(cal_busy));
    repeat (SRST_CYC) @(posedge core_clk);
    rdc(SEL_SETUP, 24'h00_00C0, "reset done");
    rdc(SEL_SETUP, 24'h00_0080, "reset done cleared");
    chk("trims after reset", ZERO_RESET, trim.zero);
    chk("span after reset", 24'h40_0000, trim.span);
    acr_host_inst.leave_reset(24'h00_0400);
    rdc(SEL_SETUP, 24'h00_0400, "after leaving reset");
    acr_host_inst.wr(SEL_SETUP, 24'h00_0000);
    // oscillation and overrange flags
    osc_detect = 1'b1;
    repeat (2) @(posedge core_clk);
    rdc(SEL_SETUP, 24'h00_0020, "osc flag set");
    osc_detect = 1'b0;
    repeat (2) @(posedge core_clk);
    rdc(SEL_SETUP, 24'h00_0000, "osc flag clear");
    foreach (OVR[i]) begin
      bipolar_mode = OVR[i][4];
      cv(24'h00_0100, OVR[i][3:1]);
      rdc(SEL_SETUP, {19'h0, OVR[i][0], 4'h0}, "overrange flag");
    end
    bipolar_mode = 1'b0;
    // all four calibrations with sequencer bits set
    acr_host_inst.wr(SEL_SETUP, 24'h07_0000);
    cal(CAL_SELF_OFS, 1'b1, ROUTE_AMP_TO_AIN_NEG, 24'h00_0010);
    chk("self offset low", 24'hFF_FFF0, trim.zero);
    cal(CAL_SELF_OFS, 1'b0, ROUTE_MOD_TO_VREF_NEG, 24'h00_0100);
    chk("self offset high", 24'hFF_FF00, trim.zero);
    cal(CAL_SELF_GAIN, 1'b0, ROUTE_MOD_ACROSS_VREF, 24'h80_0000);
    chk("self gain", 24'h7F_FFFF, trim.span);
    cal(CAL_SYS_OFS, 1'b0, ROUTE_INPUT, 24'h00_0001);
    chk("system offset", 24'hFF_FFFF, trim.zero);
    cal(CAL_SYS_GAIN, 1'b1, ROUTE_INPUT, 24'h10_0000);
    chk("system gain", 24'hFF_FFFF, trim.span);
    chk("sequencer back", 24'h00_0007, {21'h0, seq_mc, seq_lp, seq_rc});
    stop_test();
  end
endmodule : tb_top
`default_nettype wire
